// ===== cca_host_bfm.sv
`timescale 1ns/1ps
module cca_host_bfm
  import cca_pkg::*;
(
  // clock
  input wire logic aclk,
  // write channels
  output logic awvalid,
  input wire logic awready,
  output logic [ADDR_W-1:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // read channels
  output logic arvalid,
  input wire logic arready,
  output logic [ADDR_W-1:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp
);
  // idle bus at time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, awprot, arprot} = 22'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
  end

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a; // released lines never keep the old value
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do
      @(posedge aclk);
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // counter bytes stay addressed only until the answer, so few counts drop
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do
      @(posedge aclk);
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ===== cca_pkg.sv
package cca_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h11;
  localparam logic [5:0] IDX_MODE = 6'h12;
  localparam logic [5:0] IDX_HIGH = 6'h13;
  localparam logic [5:0] IDX_LOW = 6'h14;

  // field layouts
  localparam int PRESCL_LSB = 0;
  localparam int PRESCL_W = 2;
  localparam int MODE_W = 2;
  localparam int PDIV_W = 3;

  // reset values
  localparam logic [1:0] PRESCL_RESET = 2'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [PDIV_W-1:0] PDIV_RESET = 3'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // converter a operating modes
  typedef enum logic [1:0] {
    MODE_BUCK = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_BOOST = 2'b10,
    MODE_LDO = 2'b11
  } cca_opmode_t;

  // live counter value, split in bytes
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } cca_count_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } cca_rd_state_t;

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } cca_wr_state_t;
endpackage

// ===== cca_pulse_counter.sv
`timescale 1ns/1ps
module cca_pulse_counter
  import cca_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // converter side
  input wire logic pfm_pulse,
  input wire logic [PRESCL_W-1:0] prescaler,
  // readout side
  input wire logic hold,
  output cca_count_t count
);
  logic [PDIV_W-1:0] div_reg;
  logic [PDIV_W-1:0] div_next;
  logic [PDIV_W-1:0] div_limit;
  logic tick;
  cca_count_t count_reg;
  cca_count_t count_next;

  // group of 2**prescaler pulses makes one count
  always_comb
  begin
    div_limit = PDIV_W'((4'h1 << prescaler) - 4'h1);
    div_next = div_reg;
    tick = 1'b0;
    if (pfm_pulse)
    begin
      if (div_reg >= div_limit)
      begin
        div_next = PDIV_RESET;
        tick = 1'b1;
      end
      else
        div_next = div_reg + 3'h1;
    end
    // a count arriving while held is simply dropped
    count_next = count_reg;
    if (tick && !hold)
      count_next = cca_count_t'(count_reg + 16'h0001);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_reg <= PDIV_RESET;
      count_reg <= '0;
    end
    else
    begin
      div_reg <= div_next;
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

  a_hold_freezes: assert property (@(posedge aclk) disable iff (!aresetn)
    hold |=> count == $past(count))
    else $error("counter moved while held");

  a_single_prescale: assert property (@(posedge aclk) disable iff (!aresetn)
    pfm_pulse && prescaler == 2'h0 && !hold
    |=> count == cca_count_t'($past(count) + 16'h0001))
    else $error("undivided pulse not counted");

  c_count_lost: cover property (@(posedge aclk) disable iff (!aresetn)
    tick && hold);
endmodule

// ===== cca_readout.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - read-only high byte at 0x13, resets zero
// - each count is prescaled group of pulses
// - value spans high and low byte registers
// - addressing counter bytes holds off counter updates
// - high byte read copies low into shadow
// - low byte read returns shadow value
// - read-only two-bit converter a mode field
module cca_readout
  import cca_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // converter a side
  input wire logic pfm_pulse,
  input wire cca_opmode_t converter_a_mode
);
  cca_count_t count;
  logic cnt_hold;

  // read channel state
  cca_rd_state_t rd_state_reg;
  cca_rd_state_t rd_state_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic rd_cnt_reg;
  logic rd_cnt_next;
  logic [7:0] shadow_reg;
  logic [7:0] shadow_next;
  logic ar_hs;
  logic [5:0] ar_idx;
  logic ar_cnt_hit;

  // write channel state
  cca_wr_state_t wr_state_reg;
  cca_wr_state_t wr_state_next;
  logic aw_got_reg;
  logic aw_got_next;
  logic w_got_reg;
  logic w_got_next;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [ADDR_W-1:0] awaddr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic [PRESCL_W-1:0] prescl_reg;
  logic [PRESCL_W-1:0] prescl_next;
  logic aw_hs;
  logic w_hs;
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;

  cca_pulse_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .pfm_pulse(pfm_pulse),
    .prescaler(prescl_reg),
    .hold(cnt_hold),
    .count(count)
  );

  // read address decode; low two address bits ignored
  assign arready = (rd_state_reg == RD_IDLE);
  assign ar_hs = arvalid && arready;
  assign ar_idx = araddr[ADDR_W-1:2];
  assign ar_cnt_hit = (ar_idx == IDX_HIGH) || (ar_idx == IDX_LOW);

  // held from the moment the address is accepted until the data is taken,
  // so a lingering host costs counts
  assign cnt_hold = (arvalid && arready && ar_cnt_hit) || rd_cnt_reg;

  // read path next state
  always_comb
  begin
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rd_cnt_next = rd_cnt_reg;
    shadow_next = shadow_reg;
    unique case (rd_state_reg)
      RD_IDLE:
      begin
        if (ar_hs)
        begin
          rd_state_next = RD_RESP;
          rd_cnt_next = ar_cnt_hit;
          rresp_next = RESP_OKAY;
          rdata_next = '0;
          if (ar_idx == IDX_HIGH)
          begin
            rdata_next = {24'h000000, count.high};
            shadow_next = count.low;
          end
          else if (ar_idx == IDX_LOW)
            rdata_next = {24'h000000, shadow_reg};
          else if (ar_idx == IDX_MODE)
            rdata_next = {30'h0, converter_a_mode};
          else if (ar_idx == IDX_CTRL)
            rdata_next = {30'h0, prescl_reg};
          else
            rresp_next = RESP_DECERR;
        end
      end
      RD_RESP:
      begin
        if (rready)
        begin
          rd_state_next = RD_IDLE;
          rd_cnt_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_reg <= RD_IDLE;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      rd_cnt_reg <= 1'b0;
      shadow_reg <= BYTE_RESET;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      rd_cnt_reg <= rd_cnt_next;
      shadow_reg <= shadow_next;
    end
  end

  assign rvalid = (rd_state_reg == RD_RESP);
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // write side: address and data taken in either order
  assign awready = (wr_state_reg == WR_IDLE) && !aw_got_reg;
  assign wready = (wr_state_reg == WR_IDLE) && !w_got_reg;
  assign aw_hs = awvalid && awready;
  assign w_hs = wvalid && wready;
  assign aw_have = aw_got_reg || aw_hs;
  assign w_have = w_got_reg || w_hs;
  assign wr_addr = aw_got_reg ? awaddr_reg : awaddr;
  assign wr_data = w_got_reg ? wdata_reg : wdata;
  assign wr_strb = w_got_reg ? wstrb_reg : wstrb;

  // write path next state; only the control register takes data
  always_comb
  begin
    wr_state_next = wr_state_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    prescl_next = prescl_reg;
    unique case (wr_state_reg)
      WR_IDLE:
      begin
        if (aw_hs)
        begin
          aw_got_next = 1'b1;
          awaddr_next = awaddr;
        end
        if (w_hs)
        begin
          w_got_next = 1'b1;
          wdata_next = wdata;
          wstrb_next = wstrb;
        end
        if (aw_have && w_have)
        begin
          wr_state_next = WR_RESP;
          if (wr_addr[ADDR_W-1:2] == IDX_CTRL)
          begin
            bresp_next = RESP_OKAY;
            if (wr_strb[0])
              prescl_next = wr_data[PRESCL_LSB +: PRESCL_W];
          end
          else if (wr_addr[ADDR_W-1:2] == IDX_MODE
                   || wr_addr[ADDR_W-1:2] == IDX_HIGH
                   || wr_addr[ADDR_W-1:2] == IDX_LOW)
            bresp_next = RESP_SLVERR; // read-only, value untouched
          else
            bresp_next = RESP_DECERR;
        end
      end
      WR_RESP:
      begin
        if (bready)
        begin
          wr_state_next = WR_IDLE;
          aw_got_next = 1'b0;
          w_got_next = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_reg <= WR_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
      bresp_reg <= RESP_OKAY;
      prescl_reg <= PRESCL_RESET;
    end
    else
    begin
      wr_state_reg <= wr_state_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      prescl_reg <= prescl_next;
    end
  end

  assign bvalid = (wr_state_reg == WR_RESP);
  assign bresp = bresp_reg;

  // checks on the readout behaviour
  a_high_byte_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && ar_idx == IDX_HIGH
    |=> rvalid && rdata == {24'h000000, $past(count.high)})
    else $error("high byte read wrong");

  a_shadow_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && ar_idx == IDX_HIGH |=> shadow_reg == $past(count.low))
    else $error("shadow not loaded on high read");

  a_low_from_shadow: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && ar_idx == IDX_LOW |=> rdata == {24'h000000, $past(shadow_reg)})
    else $error("low read not from shadow");

  a_pair_coherent: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && ar_idx == IDX_HIGH |=> count == $past(count))
    else $error("counter moved during high read");

  a_hold_active: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rd_cnt_reg |=> $stable(count))
    else $error("hold dropped during counter read");

  a_mode_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && ar_idx == IDX_MODE |=> rdata == {30'h0, $past(converter_a_mode)})
    else $error("mode read wrong");

  a_prescl_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_state_reg == WR_IDLE && aw_have && w_have && wr_addr[ADDR_W-1:2] == IDX_CTRL
    && wr_strb[0] |=> prescl_reg == $past(wr_data[PRESCL_LSB +: PRESCL_W]) && bvalid)
    else $error("prescaler write lost");

  a_rdata_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");

  c_coherent_pair: cover property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && ar_idx == IDX_HIGH ##[1:20] ar_hs && ar_idx == IDX_LOW);
  c_write_ctrl: cover property (@(posedge aclk) disable iff (!aresetn)
    bvalid && bready && bresp == RESP_OKAY);
  c_stalled_read: cover property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rd_cnt_reg && !rready [* 3]);
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench
  import cca_pkg::*;
;
  logic aclk, aresetn, pfm_pulse;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [DATA_W-1:0] wdata, rdata, data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] exp;
  logic [31:0] rng = 32'h00000047;
  cca_opmode_t converter_a_mode;
  int err_count = 0;
  int check_count = 0;
  int tp = 0;
  int cyc = 0;

  cca_readout dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot, .rvalid, .rready, .rdata, .rresp, .pfm_pulse, .converter_a_mode);
  cca_host_bfm host_u (.aclk, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp);

  // clock, 4 ns period
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // hang guard, well above the at most about 8.5k cycles of the run
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic results();
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    check_count++;
    if (got !== e)
    begin
      err_count++;
      $display("ERROR %0t data %h expected %h", $time, got, e);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] e);
    check_count++;
    if (got !== e)
    begin
      err_count++;
      $display("ERROR %0t resp %h expected %h", $time, got, e);
    end
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                     input logic [1:0] er);
    logic [DATA_W-1:0] d;
    logic [1:0] r;
    host_u.rd(a, d, r);
    chk_data(d, e);
    chk_resp(r, er);
  endtask

  // reset also clears the pulse tally of the model
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    tp = 0;
  endtask

  // random pulse train, tallying every pulse offered
  task automatic burst(input int n);
    logic [31:0] r;
    repeat (n)
    begin
      @(posedge aclk);
      r = rnd();
      pfm_pulse <= r[0];
      tp += int'(r[0]);
    end
    @(posedge aclk);
    pfm_pulse <= 1'b0;
  endtask

  // one pass per prescaler setting and per converter mode
  initial
  begin
    aresetn = 1'b0;
    pfm_pulse = 1'b0;
    converter_a_mode = MODE_BUCK;
    for (int p = 0; p < 4; p++)
    begin
      do_reset();
      rdc(8'h4c, 32'h0, RESP_OKAY);
      rdc(8'h50, 32'h0, RESP_OKAY);
      host_u.wr(8'h44, 32'(p), resp);
      chk_resp(resp, RESP_OKAY);
      rdc(8'h44, 32'(p), RESP_OKAY);
      converter_a_mode <= cca_opmode_t'(2'(p));
      rdc(8'h48, 32'(p), RESP_OKAY);
      burst(int'(rnd() % 32'h000005dc) + 200);
      exp = 16'(tp >> p);
      rdc(8'h4c, {24'h0, exp[15:8]}, RESP_OKAY);
      burst(300);
      rdc(8'h50, {24'h0, exp[7:0]}, RESP_OKAY);
      // pulses held through a whole read are lost, the one before it is not
      pfm_pulse <= 1'b1;
      host_u.rd(8'h50, data, resp);
      pfm_pulse <= 1'b0;
      tp += 1;
      // the shadow still holds the low byte of the last high read
      chk_data(data, {24'h0, exp[7:0]});
      host_u.wr(8'h4c, 32'hff, resp);
      chk_resp(resp, RESP_SLVERR);
      host_u.wr(8'h50, 32'hff, resp);
      chk_resp(resp, RESP_SLVERR);
      host_u.wr(8'h48, 32'h3, resp);
      chk_resp(resp, RESP_SLVERR);
      host_u.wr(8'hfc, 32'h0, resp);
      chk_resp(resp, RESP_DECERR);
      rdc(8'h00, 32'h0, RESP_DECERR);
      exp = 16'(tp >> p);
      rdc(8'h4c, {24'h0, exp[15:8]}, RESP_OKAY);
      rdc(8'h50, {24'h0, exp[7:0]}, RESP_OKAY);
    end
    results();
  end
endmodule
